/* src/awr_pkg.sv */
// Shared constants and types for the alarm wake and event routing block
package awr_pkg;
    // Register byte offsets on the 32-bit bus
    localparam logic [7:0] AWR_OFS_STATUS = 8'h00;
    localparam logic [7:0] AWR_OFS_ENABLE = 8'h04;
    localparam logic [7:0] AWR_OFS_CONTROL = 8'h08;
    localparam logic [7:0] AWR_OFS_MODE_CMD = 8'h0C;
    localparam logic [7:0] AWR_OFS_DAY = 8'h10;
    localparam logic [7:0] AWR_OFS_MONTH = 8'h14;
    localparam logic [7:0] AWR_OFS_HUNDREDS = 8'h18;
    // Status register fields (write one to clear)
    localparam int AWR_STS_ALARM_BIT = 0;
    localparam int AWR_STS_WAKE_BIT = 1;
    localparam int AWR_STS_CMD_BIT = 2;
    // Enable register field
    localparam int AWR_EN_ALARM_BIT = 0;
    // Control register fields
    localparam int AWR_CTL_ROUTE_BIT = 0;
    localparam int AWR_CTL_S4_BIT = 1;
    // Reset values
    localparam logic [7:0] AWR_DAY_RESET = 8'hFF;
    localparam logic [7:0] AWR_MONTH_RESET = 8'hFF;
    localparam logic [7:0] AWR_HUNDREDS_RESET = 8'h00;
    localparam logic [7:0] AWR_CMD_RESET = 8'h00;
    // Day and month ranges
    localparam logic [7:0] AWR_DAY_MASK = 8'h3F;
    localparam logic [7:0] AWR_DAY_MIN = 8'h01;
    localparam logic [7:0] AWR_DAY_BCD_MAX = 8'h31;
    localparam logic [7:0] AWR_DAY_BIN_MAX = 8'h1F;
    localparam logic [7:0] AWR_MON_MIN = 8'h01;
    localparam logic [7:0] AWR_MON_BCD_MAX = 8'h12;
    localparam logic [7:0] AWR_MON_BIN_MAX = 8'h0C;
    localparam logic [3:0] AWR_BCD_DIGIT_MAX = 4'h9;

    // Power state reported by the sleep sequencer
    typedef enum logic [2:0] {
        AWR_S0,
        AWR_S1,
        AWR_S2,
        AWR_S3,
        AWR_S4,
        AWR_S5
    } awr_sleep_e;

    // Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } awr_wb_req_s;

    // Wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } awr_wb_rsp_s;
endpackage

/* src/awr_alarm_wake.sv */
`timescale 1ns/100ps
`default_nettype none
module awr_alarm_wake
    import awr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire awr_wb_req_s wb_req_i,
    output awr_wb_rsp_s wb_rsp_o,
    input wire logic clock_interrupt_line_i,
    input wire logic battery_low_i,
    input wire logic legacy_capable_i,
    input wire logic alarm_bcd_mode_i,
    input wire awr_sleep_e sleep_state_i,
    output logic wake_event_o,
    output logic os_control_interrupt_o,
    output logic firmware_mgmt_interrupt_o,
    output logic day_alarm_valid_o,
    output logic month_alarm_valid_o,
    output logic [7:0] day_of_month_alarm_o,
    output logic [7:0] month_of_year_alarm_o,
    output logic [7:0] year_hundreds_value_o
);

    // Whole state of the block
    typedef struct packed {
        logic ack;                 // Bus answer strobe
        logic [31:0] rdat;         // Read data holder
        logic irq_s1;              // Clock line, first sync stage
        logic irq_s2;              // Clock line, second sync stage
        logic irq_d;               // Clock line, edge history
        logic bat_s1;              // Battery-low first stage
        logic bat_s2;              // Battery-low second stage
        logic leg_s1;              // Legacy strap first stage
        logic leg_s2;              // Legacy strap second stage
        logic alarm_sts;           // Sticky alarm wake status
        logic alarm_en;            // Alarm wake enable
        logic wake_sts;            // Sticky wake status
        logic cmd_sts;             // Pending command port event
        logic route;               // Stored route select
        logic s4_flag;             // Deep sleep alarm wake flag
        logic [7:0] cmd_val;       // Last command byte written
        logic [7:0] day;           // Day of month alarm
        logic [7:0] mon;           // Month of year alarm
        logic [7:0] year_hundreds_value;          // Year hundreds value
    } awr_state_s;

    awr_state_s st_ff;      // Registered state
    awr_state_s nxt_st;     // Next state

    // Valid day of month, upper two bits ignored
    function automatic logic day_ok(input logic [7:0] v, input logic bcd);
        logic [7:0] m;
        m = v & AWR_DAY_MASK;
        if (bcd) begin
            day_ok = (m >= AWR_DAY_MIN) && (m <= AWR_DAY_BCD_MAX)
                     && (m[3:0] <= AWR_BCD_DIGIT_MAX);
        end else begin
            day_ok = (m >= AWR_DAY_MIN) && (m <= AWR_DAY_BIN_MAX);
        end
    endfunction

    // Valid month of year
    function automatic logic mon_ok(input logic [7:0] v, input logic bcd);
        if (bcd) begin
            mon_ok = (v >= AWR_MON_MIN) && (v <= AWR_MON_BCD_MAX)
                     && (v[3:0] <= AWR_BCD_DIGIT_MAX);
        end else begin
            mon_ok = (v >= AWR_MON_MIN) && (v <= AWR_MON_BIN_MAX);
        end
    endfunction

    // Decoded bus access
    logic bus_req;          // New request not yet answered
    logic wr_hit;           // Write with low lane enabled
    logic irq_rise;         // Alarm edge on the clock line
    logic route_eff;        // Route select as seen by software
    logic sleeping;         // System in a sleeping state
    logic wake_allowed;     // Present state may wake on alarm
    logic pm_event;         // Management event from alarm
    logic day_v;            // Day alarm holds a valid day
    logic mon_v;            // Month alarm usable

    assign bus_req = wb_req_i.cyc && wb_req_i.stb && !st_ff.ack;
    assign wr_hit = bus_req && wb_req_i.we && wb_req_i.sel[0];
    assign irq_rise = st_ff.irq_s2 && !st_ff.irq_d;

    // Route forced on without legacy mode
    assign route_eff = st_ff.route || !st_ff.leg_s2;

    // Sleeping states S1 through S4
    assign sleeping = (sleep_state_i == AWR_S1) || (sleep_state_i == AWR_S2)
                      || (sleep_state_i == AWR_S3) || (sleep_state_i == AWR_S4);

    // S4 only with the deep sleep flag
    assign wake_allowed = sleeping && ((sleep_state_i != AWR_S4) || st_ff.s4_flag);

    // Status and enable raise an event
    assign pm_event = st_ff.alarm_sts && st_ff.alarm_en;

    // Unused day value falls back to daily alarm
    assign day_v = day_ok(st_ff.day, alarm_bcd_mode_i);

    // Month match only with day match
    assign mon_v = day_v && mon_ok(st_ff.mon, alarm_bcd_mode_i);

    // Next state, bus and event logic
    always_comb begin
        nxt_st = st_ff;
        // Two-stage synchronisers for pins
        nxt_st.irq_s1 = clock_interrupt_line_i;
        nxt_st.irq_s2 = st_ff.irq_s1;
        nxt_st.irq_d = st_ff.irq_s2;
        nxt_st.bat_s1 = battery_low_i;
        nxt_st.bat_s2 = st_ff.bat_s1;
        nxt_st.leg_s1 = legacy_capable_i;
        nxt_st.leg_s2 = st_ff.leg_s1;
        // Answer one cycle after request, then drop
        nxt_st.ack = bus_req;
        nxt_st.rdat = 32'h0000_0000;
        // Read mux, unmapped reads zero
        if (bus_req && !wb_req_i.we) begin
            case (wb_req_i.adr)
                AWR_OFS_STATUS: begin
                    nxt_st.rdat[AWR_STS_ALARM_BIT] = st_ff.alarm_sts;
                    nxt_st.rdat[AWR_STS_WAKE_BIT] = st_ff.wake_sts;
                    nxt_st.rdat[AWR_STS_CMD_BIT] = st_ff.cmd_sts;
                end
                AWR_OFS_ENABLE: begin
                    nxt_st.rdat[AWR_EN_ALARM_BIT] = st_ff.alarm_en;
                end
                AWR_OFS_CONTROL: begin
                    nxt_st.rdat[AWR_CTL_ROUTE_BIT] = route_eff;
                    nxt_st.rdat[AWR_CTL_S4_BIT] = st_ff.s4_flag;
                end
                AWR_OFS_MODE_CMD: begin
                    nxt_st.rdat[7:0] = st_ff.cmd_val;
                end
                AWR_OFS_DAY: begin
                    nxt_st.rdat[7:0] = st_ff.day;
                end
                AWR_OFS_MONTH: begin
                    nxt_st.rdat[7:0] = st_ff.mon;
                end
                AWR_OFS_HUNDREDS: begin
                    nxt_st.rdat[7:0] = st_ff.year_hundreds_value;
                end
                default: begin
                    nxt_st.rdat = 32'h0000_0000;
                end
            endcase
        end
        // Register writes, low byte lane only
        if (wr_hit) begin
            case (wb_req_i.adr)
                AWR_OFS_STATUS: begin
                    if (wb_req_i.dat[AWR_STS_ALARM_BIT]) begin
                        nxt_st.alarm_sts = 1'b0;
                    end
                    if (wb_req_i.dat[AWR_STS_WAKE_BIT]) begin
                        nxt_st.wake_sts = 1'b0;
                    end
                    if (wb_req_i.dat[AWR_STS_CMD_BIT]) begin
                        nxt_st.cmd_sts = 1'b0;
                    end
                end
                AWR_OFS_ENABLE: begin
                    nxt_st.alarm_en = wb_req_i.dat[AWR_EN_ALARM_BIT];
                end
                AWR_OFS_CONTROL: begin
                    nxt_st.route = wb_req_i.dat[AWR_CTL_ROUTE_BIT];
                    nxt_st.s4_flag = wb_req_i.dat[AWR_CTL_S4_BIT];
                end
                AWR_OFS_MODE_CMD: begin
                    nxt_st.cmd_val = wb_req_i.dat[7:0];
                    nxt_st.cmd_sts = 1'b1;
                end
                AWR_OFS_DAY: begin
                    nxt_st.day = wb_req_i.dat[7:0];
                end
                AWR_OFS_MONTH: begin
                    nxt_st.mon = wb_req_i.dat[7:0];
                end
                AWR_OFS_HUNDREDS: begin
                    nxt_st.year_hundreds_value = wb_req_i.dat[7:0];
                end
                default: begin
                    nxt_st.cmd_val = st_ff.cmd_val;
                end
            endcase
        end
        // Alarm edge sets status, set beats clear
        // Edge taken from the clock line
        if (irq_rise) begin
            nxt_st.alarm_sts = 1'b1;
        end
        // Wake in sleep sets wake status
        if (wake_event_o) begin
            nxt_st.wake_sts = 1'b1;
        end
        // Synchronous reset of control state
        if (rst_i) begin
            nxt_st = '0;
            nxt_st.day = AWR_DAY_RESET;
            nxt_st.mon = AWR_MONTH_RESET;
            nxt_st.year_hundreds_value = AWR_HUNDREDS_RESET;
            nxt_st.cmd_val = AWR_CMD_RESET;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    // Bus answer from flip-flops
    assign wb_rsp_o.ack = st_ff.ack;
    assign wb_rsp_o.dat = st_ff.rdat;

    // Wake request while sleeping, not on battery low
    assign wake_event_o = pm_event && wake_allowed && !st_ff.bat_s2;

    assign os_control_interrupt_o = pm_event && route_eff;
    assign firmware_mgmt_interrupt_o = (pm_event && !route_eff) || st_ff.cmd_sts;

    // Alarm bytes held in fixed storage
    assign day_of_month_alarm_o = st_ff.day;
    assign month_of_year_alarm_o = st_ff.mon;
    assign year_hundreds_value_o = st_ff.year_hundreds_value;
    assign day_alarm_valid_o = day_v;
    assign month_alarm_valid_o = mon_v;

    // Checks on the block's own behaviour
    default clocking awr_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_alarm_sets;
        irq_rise |=> st_ff.alarm_sts;
    endproperty
    a_alarm_sets: assert property (p_alarm_sets) else $error("alarm edge lost");

    property p_sticky;
        st_ff.alarm_sts && !(wr_hit && wb_req_i.adr == AWR_OFS_STATUS
            && wb_req_i.dat[AWR_STS_ALARM_BIT]) |=> st_ff.alarm_sts;
    endproperty
    a_sticky: assert property (p_sticky) else $error("alarm status dropped");

    property p_wake;
        pm_event && (sleep_state_i == AWR_S1) && !st_ff.bat_s2 |-> wake_event_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake in S1");

    property p_s4;
        (sleep_state_i == AWR_S4) && !st_ff.s4_flag |-> !wake_event_o;
    endproperty
    a_s4: assert property (p_s4) else $error("S4 wake without flag");

    property p_off;
        (sleep_state_i == AWR_S0) || (sleep_state_i == AWR_S5) |-> !wake_event_o;
    endproperty
    a_off: assert property (p_off) else $error("wake outside sleep");

    property p_route_fw;
        pm_event && !route_eff |-> firmware_mgmt_interrupt_o && !os_control_interrupt_o;
    endproperty
    a_route_fw: assert property (p_route_fw) else $error("legacy route wrong");

    property p_route_os;
        !pm_event |-> !os_control_interrupt_o;
    endproperty
    a_route_os: assert property (p_route_os) else $error("spurious os interrupt");

    property p_no_legacy;
        bus_req && !wb_req_i.we && wb_req_i.adr == AWR_OFS_CONTROL && !st_ff.leg_s2
            |=> wb_rsp_o.dat[AWR_CTL_ROUTE_BIT];
    endproperty
    a_no_legacy: assert property (p_no_legacy) else $error("route not forced");

    property p_cmd;
        wr_hit && wb_req_i.adr == AWR_OFS_MODE_CMD |=> firmware_mgmt_interrupt_o;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command gave no event");

    property p_wake_sts;
        wake_event_o |=> st_ff.wake_sts;
    endproperty
    a_wake_sts: assert property (p_wake_sts) else $error("wake status not set");

    property p_month_day;
        month_alarm_valid_o |-> day_alarm_valid_o;
    endproperty
    a_month_day: assert property (p_month_day) else $error("month without day");

    property p_ack;
        bus_req |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer timing wrong");

    c_wake: cover property (irq_rise ##[1:8] wake_event_o);
    c_legacy: cover property (pm_event && !route_eff);
    c_mode: cover property (wr_hit && wb_req_i.adr == AWR_OFS_MODE_CMD ##[1:50] route_eff);
    c_clear: cover property (st_ff.alarm_sts ##1 !st_ff.alarm_sts);

endmodule
`default_nettype wire

/* test/awr_rtc_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Clock chip seen from the block: only its alarm drives the line
module awr_rtc_model (
    input wire logic clk_i,
    input wire logic fire_i,
    output logic clock_interrupt_line_o
);
    logic [2:0] hold_cnt = 3'h0; // Cycles left on the alarm pulse
    always @(posedge clk_i) begin
        if (fire_i) begin
            hold_cnt <= 3'h4;
        end else if (hold_cnt != 3'h0) begin
            hold_cnt <= hold_cnt - 3'h1;
        end
    end
    // Line idles low between alarms
    assign clock_interrupt_line_o = (hold_cnt != 3'h0);
endmodule
`default_nettype wire

/* test/alarm_wake_and_event_routing_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module alarm_wake_and_event_routing_test import awr_pkg::*; ;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fire = 1'b0, batt = 1'b0, leg = 1'b1, bcd = 1'b0;
    logic irq, wake, osi, fwi, dval, mval;
    logic [7:0] day_q, mon_q, hun_q, d, m, h;
    logic [31:0] q;
    logic [7:0] corner [8] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h31, 8'h32, 8'h0C, 8'h12};
    awr_sleep_e slp = AWR_S0;
    awr_wb_req_s req = '0;
    awr_wb_rsp_s rsp;
    int n_fail = 0, samples_checked = 0, seed = 96032;
    // Free running bus clock
    always #20 clk_i = ~clk_i;
    awr_alarm_wake awr_alarm_wake_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_rsp_o(rsp), .clock_interrupt_line_i(irq), .battery_low_i(batt),
        .legacy_capable_i(leg), .alarm_bcd_mode_i(bcd), .sleep_state_i(slp),
        .wake_event_o(wake), .os_control_interrupt_o(osi),
        .firmware_mgmt_interrupt_o(fwi), .day_alarm_valid_o(dval),
        .month_alarm_valid_o(mval), .day_of_month_alarm_o(day_q),
        .month_of_year_alarm_o(mon_q), .year_hundreds_value_o(hun_q));
    awr_rtc_model awr_rtc_model_inst (.clk_i(clk_i), .fire_i(fire),
        .clock_interrupt_line_o(irq));
    // Day byte in range, top two bits ignored
    function automatic logic day_ok(logic [7:0] v, logic b);
        logic [7:0] x;
        x = v & 8'h3F;
        return x >= 8'h01 && (b ? (x <= 8'h31 && x[3:0] <= 4'h9) : x <= 8'h1F);
    endfunction
    // Month byte in range
    function automatic logic mon_ok(logic [7:0] v, logic b);
        return v >= 8'h01 && (b ? (v <= 8'h12 && v[3:0] <= 4'h9) : v <= 8'h0C);
    endfunction
    // One classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'hF, a, dt};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 16);
        `CHK("ack", 1'b1, rsp.ack)
        q = rsp.dat;
        req <= '0;
    endtask
    // Read and compare a register
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask
    // Let synced inputs land, then look
    task automatic settle;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Fire one alarm and wait out sync
    task automatic alarm;
        @(posedge clk_i) fire <= 1'b1;
        @(posedge clk_i) fire <= 1'b0;
        repeat (7) @(posedge clk_i);
    endtask
    // Counts, verdict, end of run
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(AWR_OFS_DAY, 32'hFF, "day rst"); // daily fallback
        rd(AWR_OFS_MONTH, 32'hFF, "mon rst"); // unused month
        rd(AWR_OFS_HUNDREDS, 32'h0, "hund rst"); // hundreds byte
        rd(AWR_OFS_CONTROL, 32'h0, "route rst"); // legacy route
        rd(8'h40, 32'h0, "unmapped"); // no stray bits
        alarm();
        rd(AWR_OFS_STATUS, 32'h1, "sts noen"); // set without enable
        `CHK("wake noen", 1'b0, wake) // enable needed
        wb(1'b1, AWR_OFS_STATUS, 32'h0);
        rd(AWR_OFS_STATUS, 32'h1, "sts w0"); // zero keeps bit
        wb(1'b1, AWR_OFS_STATUS, 32'h1);
        rd(AWR_OFS_STATUS, 32'h0, "sts w1"); // one clears bit
        wb(1'b1, AWR_OFS_ENABLE, 32'h1);
        alarm();
        for (int f = 0; f < 2; f++) begin
            wb(1'b1, AWR_OFS_CONTROL, {30'h0, f[0], 1'b1});
            for (int i = 0; i < 6; i++) begin
                if (i == 5) wb(1'b1, AWR_OFS_ENABLE, 32'h0);
                slp <= awr_sleep_e'(i);
                settle();
                `CHK("wake st", (i >= 1 && i <= 3) || (i == 4 && f == 1), wake) // states
            end
            slp <= AWR_S0;
            wb(1'b1, AWR_OFS_ENABLE, 32'h1);
        end
        slp <= AWR_S3;
        batt <= 1'b1;
        settle();
        `CHK("wake batt", 1'b0, wake) // battery low blocks
        batt <= 1'b0;
        settle();
        `CHK("wake s3", 1'b1, wake) // alarm wakes
        rd(AWR_OFS_STATUS, 32'h3, "wake sts"); // wake status set
        slp <= AWR_S0;
        wb(1'b1, AWR_OFS_CONTROL, 32'h0);
        settle();
        `CHK("fw route0", 1'b1, fwi) // legacy route
        `CHK("os route0", 1'b0, osi) // legacy route
        wb(1'b1, AWR_OFS_CONTROL, 32'h1);
        settle();
        `CHK("os route1", 1'b1, osi) // level held
        `CHK("fw route1", 1'b0, fwi) // os route
        wb(1'b1, AWR_OFS_STATUS, 32'h7);
        settle();
        `CHK("os clr", 1'b0, osi) // cause gone
        wb(1'b1, AWR_OFS_CONTROL, 32'h0);
        rd(AWR_OFS_CONTROL, 32'h0, "route pre"); // legacy confirmed
        h = 8'($random(seed));
        wb(1'b1, AWR_OFS_MODE_CMD, {24'h0, h}); // enable command
        settle();
        `CHK("fw cmd", 1'b1, fwi) // command raises
        rd(AWR_OFS_STATUS, 32'h4, "cmd sts"); // pending seen
        rd(AWR_OFS_MODE_CMD, {24'h0, h}, "cmd byte"); // byte kept
        wb(1'b1, AWR_OFS_CONTROL, 32'h1);
        wb(1'b1, AWR_OFS_STATUS, 32'h4);
        rd(AWR_OFS_CONTROL, 32'h1, "route ack"); // firmware sets
        `CHK("fw done", 1'b0, fwi) // pending cleared
        wb(1'b1, AWR_OFS_MODE_CMD, {24'h0, ~h}); // disable command
        `CHK("fw cmd2", 1'b1, fwi) // command raises
        wb(1'b1, AWR_OFS_STATUS, 32'h4);
        wb(1'b1, AWR_OFS_CONTROL, 32'h0);
        rd(AWR_OFS_CONTROL, 32'h0, "route back"); // polled clear
        for (int k = 0; k < 32; k++) begin
            d = (k < 8) ? corner[k] : 8'($random(seed));
            m = (k < 8) ? corner[7 - k] : 8'($random(seed));
            h = 8'($random(seed));
            bcd <= k[0];
            wb(1'b1, AWR_OFS_DAY, {24'h0, d});
            wb(1'b1, AWR_OFS_MONTH, {24'h0, m});
            wb(1'b1, AWR_OFS_HUNDREDS, {24'h0, h});
            rd(AWR_OFS_DAY, {24'h0, d}, "day rd"); // byte stored
            @(negedge clk_i);
            `CHK("day ok", day_ok(d, k[0]), dval) // day range
            `CHK("mon ok", mon_ok(m, k[0]) && day_ok(d, k[0]), mval) // needs day
            `CHK("day q", d, day_q) // byte on pins
            `CHK("mon q", m, mon_q) // month byte
            `CHK("hund q", h, hun_q) // hundreds byte
        end
        leg <= 1'b0;
        settle();
        rd(AWR_OFS_CONTROL, 32'h1, "route fix"); // reads one
        wb(1'b1, AWR_OFS_CONTROL, 32'h0);
        rd(AWR_OFS_CONTROL, 32'h1, "route wr"); // still forced on
        give_verdict();
    end
endmodule
`default_nettype wire
